// File: dv/mpw_contact_model.sv
// Purpose: Model of the output contacts seen by the driven plant.
// Assumes: One clock, contacts sampled on the rising edge.
// Notes: Counts high cycles on one contact and flags any other one.
`timescale 1ns/10ps
module mpw_contact_model (
    // Clock and window control
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [2:0] sel_i,
    // Observed contacts
    input wire logic [7:0] pwm_i,
    // Window results
    output int hi_cnt_o,
    output int tot_cnt_o,
    output logic stray_o
);
    // Window counters; clear restarts a window on a whole cycle
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            hi_cnt_o <= 0;
            tot_cnt_o <= 0;
            stray_o <= 1'b0;
        end else begin
            hi_cnt_o <= hi_cnt_o + int'(pwm_i[sel_i]);
            tot_cnt_o <= tot_cnt_o + 1;
            stray_o <= stray_o | (|(pwm_i & ~(8'h01 << sel_i)));
        end
    end
endmodule : mpw_contact_model

// File: dv/mpw_top_bench.sv
// Purpose: Register-driven test of the pulse width block.
// Assumes: 20 MHz clock, one full wave cycle of 2000 clocks at period 1.
// Notes: Duty is measured over two whole cycles, so phase does not matter.
`timescale 1ns/10ps
module mpw_top_bench;
    import mpw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] claim = 8'h00;
    logic flt = 1'b0;
    logic clr = 1'b0;
    logic [31:0] rdata;
    logic [7:0] pwm;
    logic valid, busy, fault, irq, stray;
    logic [2:0] code;
    int hi, tot;
    int fails = 0;
    int num_checks = 0;
    // Parameter fault table: ms limit edge, us limit edge and the firmware, reuse, period and runtime codes
    logic [31:0] f_ctl [7] = '{32'h001, 32'h121, 32'h103, 32'h103, 32'h101, 32'h101, 32'h101};
    logic [15:0] f_per [7] = '{16'h1, 16'h1, 16'hA7C6, 16'hA7C5, 16'h0, 16'hFFFF, 16'h1};
    logic [7:0] f_clm [7] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0] f_code [7] = '{3'h1, 3'h3, 3'h5, 3'h0, 3'h5, 3'h0, 3'h6};

    mpw_top #(.NUM_PINS(8)) dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
        .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .PIN_CLAIMED_I(claim), .RUN_FAULT_I(flt),
        .PWM_OUT_O(pwm), .OUT_VALID_O(valid), .IN_PROGRESS_O(busy), .FAULT_FLAG_O(fault),
        .FAULT_CODE_O(code), .IRQ_O(irq));
    mpw_contact_model u_model (.clk_i(clk), .clr_i(clr), .sel_i(3'h3), .pwm_i(pwm),
        .hi_cnt_o(hi), .tot_cnt_o(tot), .stray_o(stray));

    // Clock
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk

    task automatic chk_near(input string n, input int e, input int g);
        num_checks++;
        if (g < e - 40 || g > e + 40) begin
            fails++;
            $display("unexpected %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_near

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Two whole wave cycles on contact 3; first cycle lets the duty land
    task automatic meas(input int duty);
        cyc(2100);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        cyc(4000);
        chk_near("high count", duty * 40, hi);
    endtask : meas

    task automatic results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Watchdog: the sequence needs about 20000 cycles, allow three times that
    initial begin
        #3000000;
        fails++;
        results;
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(MPW_REG_CTRL, 32'h100, "ctrl");
        rd(MPW_REG_PERIOD, 32'h1, "period");
        rd(MPW_REG_DUTY, 32'h0, "duty");
        rd(MPW_REG_STATUS, 32'h0, "status");
        rd(4'hF, 32'h0, "unmapped");
        wr(MPW_REG_IRQ_MASK, 32'h7);
        // Start on contact 3 at half duty; status lands one edge after the write edge
        wr(MPW_REG_DUTY, 32'h32);
        wr(MPW_REG_CTRL, 32'h131);
        #1;
        chk("valid early", 32'h0, 32'(valid));
        cyc(1);
        chk("valid", 32'h1, 32'(valid));
        chk("busy", 32'h1, 32'(busy));
        meas(50);
        chk("irq start", 32'h1, 32'(irq));
        // Out-of-range duty saturates, then zero duty
        wr(MPW_REG_DUTY, 32'hC8);
        rd(MPW_REG_DUTY, 32'h64, "duty sat");
        meas(100);
        wr(MPW_REG_DUTY, 32'h0);
        meas(0);
        wr(MPW_REG_CTRL, 32'h130);
        cyc(3);
        chk("busy stop", 32'h0, 32'(busy));
        chk("stray", 32'h0, 32'(stray));
        rd(MPW_REG_IRQ_STAT, 32'h5, "irq stat");
        wr(MPW_REG_IRQ_STAT, 32'h7);
        wr(MPW_REG_IRQ_MASK, 32'h2);
        cyc(2);
        chk("irq clear", 32'h0, 32'(irq));
        // Parameter faults and legal limit edges, runtime fault, then recovery on run low
        for (int i = 0; i < 7; i++) begin
            claim <= f_clm[i];
            wr(MPW_REG_PERIOD, {16'h0, f_per[i]});
            wr(MPW_REG_CTRL, f_ctl[i]);
            cyc(4);
            if (i == 6) begin
                flt <= 1'b1;
                cyc(4);
            end
            chk("fault", 32'(f_code[i] != 3'h0), 32'(fault));
            chk("code", 32'(f_code[i]), 32'(code));
            chk("busy", 32'(f_code[i] == 3'h0), 32'(busy));
            chk("irq fault", 32'(f_code[i] != 3'h0), 32'(irq));
            wr(MPW_REG_IRQ_STAT, 32'h7);
            wr(MPW_REG_CTRL, 32'h100);
            flt <= 1'b0;
            cyc(4);
            chk("fault off", 32'h0, 32'(fault));
            chk("code off", 32'h0, 32'(code));
        end
        results;
    end
endmodule : mpw_top_bench

// File: dv/mpw_top_sva.sv
// Purpose: Port checker for the pulse width block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Watches top-level ports only.
`timescale 1ns/10ps
module mpw_top_sva #(
    parameter int NUM_PINS = 8
) (
    // Clock, reset and stimulus
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic REG_RD_I,
    input wire logic RUN_FAULT_I,
    // Outputs under watch
    input wire logic [31:0] REG_RDATA_O,
    input wire logic [NUM_PINS-1:0] PWM_OUT_O,
    input wire logic OUT_VALID_O,
    input wire logic IN_PROGRESS_O,
    input wire logic FAULT_FLAG_O,
    input wire logic [2:0] FAULT_CODE_O
);
    import mpw_pkg::*;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // Status relations
    a_valid_busy_pair: assert property (OUT_VALID_O == IN_PROGRESS_O)
        else $error("valid and busy differ");
    a_start_clean: assert property ($rose(IN_PROGRESS_O) |-> OUT_VALID_O && !FAULT_FLAG_O)
        else $error("start without clean status");
    a_fault_idle: assert property (FAULT_FLAG_O |-> !OUT_VALID_O && PWM_OUT_O == '0)
        else $error("fault while driving");
    a_code_match: assert property (FAULT_FLAG_O == (FAULT_CODE_O != MPW_ERR_NONE))
        else $error("fault code and flag disagree");
    a_runtime_fault: assert property ($rose(RUN_FAULT_I) && IN_PROGRESS_O |->
        ##[1:3] (FAULT_FLAG_O && FAULT_CODE_O == MPW_ERR_RUNTIME))
        else $error("runtime fault missed");
    // Contact relations; one cycle of lag allowed for the output register
    a_idle_quiet: assert property (!IN_PROGRESS_O [*2] |-> PWM_OUT_O == '0)
        else $error("contact driven while idle");
    a_single_pin: assert property ($onehot0(PWM_OUT_O))
        else $error("more than one contact driven");
    // Read data only after a read strobe
    a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == '0)
        else $error("read data without read");
endmodule : mpw_top_sva

bind mpw_top mpw_top_sva #(.NUM_PINS(NUM_PINS)) u_sva (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
    .REG_RD_I(REG_RD_I), .RUN_FAULT_I(RUN_FAULT_I), .REG_RDATA_O(REG_RDATA_O), .PWM_OUT_O(PWM_OUT_O),
    .OUT_VALID_O(OUT_VALID_O), .IN_PROGRESS_O(IN_PROGRESS_O), .FAULT_FLAG_O(FAULT_FLAG_O),
    .FAULT_CODE_O(FAULT_CODE_O));

// File: rtl/mpw_pkg.sv
// Purpose: Constants and types for the multichannel pulse width output block.
// Assumes: 20 MHz reference clock, synchronous active-high reset.
// Notes: Register offsets are word indices on the plain register port.
// Function
// - Run rising edge starts wave, valid, busy
// - Contact selector 0..7, default zero
// - Microsecond or millisecond base, period ranges
// - Contact, base, period only used while running
// - Square wave high fraction follows duty percent
// - Valid and busy drop on fault/run low
// - Illegal parameter or runtime fault sets fault
// - Fault and code clear when run falls
// - Fault stops waveform on selected contact
// - Waveform only reaches output contacts
// - Distinct codes for each parameter fault
// - Contact reuse flagged with own code
package mpw_pkg;
    // Register indices
    localparam logic [3:0] MPW_REG_CTRL = 4'h0;
    localparam logic [3:0] MPW_REG_PERIOD = 4'h1;
    localparam logic [3:0] MPW_REG_DUTY = 4'h2;
    localparam logic [3:0] MPW_REG_STATUS = 4'h3;
    localparam logic [3:0] MPW_REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] MPW_REG_IRQ_MASK = 4'h5;
    localparam logic [3:0] MPW_REG_CLAIMED = 4'h6;
    // Control field positions
    localparam int MPW_CTRL_RUN_BIT = 0;
    localparam int MPW_CTRL_BASE_BIT = 1;
    localparam int MPW_CTRL_PIN_LSB = 4;
    localparam int MPW_CTRL_FW_BIT = 8;
    // Interrupt bit positions
    localparam int MPW_IRQ_START_BIT = 0;
    localparam int MPW_IRQ_FAULT_BIT = 1;
    localparam int MPW_IRQ_STOP_BIT = 2;
    // Reset values
    localparam logic [15:0] MPW_PERIOD_RST = 16'h0001;
    localparam logic [6:0] MPW_DUTY_RST = 7'h00;
    localparam logic [2:0] MPW_PIN_RST = 3'h0;
    // Legal ranges
    localparam logic [15:0] MPW_PERIOD_MIN = 16'h0001;
    localparam logic [15:0] MPW_MS_PERIOD_MAX = 16'hA7C5;
    localparam logic [6:0] MPW_DUTY_MAX = 7'h64;
    // Timing: cycles per microsecond and per millisecond at 20 MHz
    localparam int MPW_CLK_MHZ = 20;
    localparam int MPW_US_PER_MS = 1000;
    localparam logic [15:0] MPW_CYC_PER_US = 16'(MPW_CLK_MHZ);
    localparam logic [15:0] MPW_CYC_PER_MS = 16'(MPW_CLK_MHZ * MPW_US_PER_MS);

    typedef enum logic {
        MPW_BASE_US = 1'b0,
        MPW_BASE_MS = 1'b1
    } mpw_base_type;

    typedef enum logic [2:0] {
        MPW_ERR_NONE = 3'b000,
        MPW_ERR_FW = 3'b001,
        MPW_ERR_PIN_RANGE = 3'b010,
        MPW_ERR_PIN_USED = 3'b011,
        MPW_ERR_BASE = 3'b100,
        MPW_ERR_PERIOD = 3'b101,
        MPW_ERR_RUNTIME = 3'b110
    } mpw_fault_type;

    typedef enum logic [1:0] {
        MPW_ST_IDLE = 2'b00,
        MPW_ST_RUN = 2'b01,
        MPW_ST_FAULT = 2'b10
    } mpw_state_type;
endpackage : mpw_pkg

// File: rtl/mpw_tick.sv
// Purpose: Time base tick generator for the pulse width block.
// Assumes: Clock rate fixed by package constants.
// Notes: Restarts whenever clr_i is high so a new run begins aligned.
`timescale 1ns/10ps
module mpw_tick (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clr_i,
    input wire logic base_ms_i,
    // Tick
    output logic tick_o
);
    import mpw_pkg::*;

    logic [15:0] cnt_q;
    logic [15:0] limit;

    // Millisecond base needs 20000 cycles, still fits 16 bits
    assign limit = base_ms_i ? MPW_CYC_PER_MS : MPW_CYC_PER_US;

    // Free running divider, one pulse per time unit
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_q == limit - 16'h0001) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : mpw_tick

// File: rtl/mpw_top.sv
// Purpose: Eight-contact pulse width output with fault reporting.
// Assumes: Plain register port, read data one cycle after strobe.
// Notes: Duty is applied only at period boundaries to avoid glitches.
`timescale 1ns/10ps
module mpw_top #(
    parameter int NUM_PINS = 8
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    // Register port
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // Contacts claimed by other generators
    input wire logic [NUM_PINS-1:0] PIN_CLAIMED_I,
    // Runtime fault from the output stage
    input wire logic RUN_FAULT_I,
    // Output contacts
    output logic [NUM_PINS-1:0] PWM_OUT_O,
    // Status
    output logic OUT_VALID_O,
    output logic IN_PROGRESS_O,
    output logic FAULT_FLAG_O,
    output logic [2:0] FAULT_CODE_O,
    output logic IRQ_O
);
    import mpw_pkg::*;

    typedef struct packed {
        logic run_request;
        logic run_prev;
        mpw_base_type period_time_base;
        logic [2:0] pin_sel;
        logic fw_ok;
        logic [15:0] period_val;
        logic [6:0] duty_percent;
        mpw_state_type state;
        mpw_fault_type fault_code;
        logic [2:0] act_pin;
        logic [15:0] act_period;
        logic [6:0] act_duty;
        logic [15:0] unit_cnt;
        logic [6:0] hund_cnt;
        logic [NUM_PINS-1:0] pwm_out;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
        logic irq;
    } mpw_regs_type;

    mpw_regs_type r_q, r_d;
    logic tick;
    logic run_rise;
    logic run_fall;
    mpw_fault_type chk;
    logic [2:0] ev;

    // Unit tick; cleared outside a run so every period starts whole
    mpw_tick u_tick (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .clr_i(r_q.state != MPW_ST_RUN),
        .base_ms_i(r_q.act_period == 16'h0000 ? r_q.period_time_base == MPW_BASE_MS
                   : r_q.period_time_base == MPW_BASE_MS),
        .tick_o(tick)
    );

    // Parameter check, priority order: firmware, contact, reuse, base, period
    function automatic mpw_fault_type check_params(input logic fw, input logic [2:0] pin,
                                                   input logic [NUM_PINS-1:0] claimed,
                                                   input mpw_base_type base, input logic [15:0] per);
        mpw_fault_type res;
        res = MPW_ERR_NONE;
        if (!fw) begin
            res = MPW_ERR_FW;
        end else if (32'(pin) >= NUM_PINS) begin
            res = MPW_ERR_PIN_RANGE;
        end else if (claimed[pin]) begin
            res = MPW_ERR_PIN_USED;
        end else if (base != MPW_BASE_US && base != MPW_BASE_MS) begin
            res = MPW_ERR_BASE;
        end else if (per < MPW_PERIOD_MIN || (base == MPW_BASE_MS && per > MPW_MS_PERIOD_MAX)) begin
            res = MPW_ERR_PERIOD;
        end
        return res;
    endfunction : check_params

    assign run_rise = r_q.run_request && !r_q.run_prev;
    assign run_fall = !r_q.run_request && r_q.run_prev;
    assign chk = check_params(r_q.fw_ok, r_q.pin_sel, PIN_CLAIMED_I, r_q.period_time_base, r_q.period_val);

    // Next state of the whole block
    always_comb begin
        r_d = r_q;
        ev = 3'h0;
        r_d.run_prev = r_q.run_request;
        r_d.rdata = 32'h0000_0000;

        // Register writes
        if (REG_WR_I) begin
            if (REG_ADDR_I == MPW_REG_CTRL) begin
                r_d.run_request = REG_WDATA_I[MPW_CTRL_RUN_BIT];
                r_d.period_time_base = mpw_base_type'(REG_WDATA_I[MPW_CTRL_BASE_BIT]);
                r_d.pin_sel = REG_WDATA_I[MPW_CTRL_PIN_LSB +: 3];
                r_d.fw_ok = REG_WDATA_I[MPW_CTRL_FW_BIT];
            end else if (REG_ADDR_I == MPW_REG_PERIOD) begin
                r_d.period_val = REG_WDATA_I[15:0];
            end else if (REG_ADDR_I == MPW_REG_DUTY) begin
                // Out of range duty saturates rather than faulting
                r_d.duty_percent = (REG_WDATA_I[31:0] > 32'(MPW_DUTY_MAX)) ? MPW_DUTY_MAX
                                   : REG_WDATA_I[6:0];
            end else if (REG_ADDR_I == MPW_REG_IRQ_MASK) begin
                r_d.irq_mask = REG_WDATA_I[2:0];
            end
        end

        // Register reads, answer next cycle
        if (REG_RD_I) begin
            if (REG_ADDR_I == MPW_REG_CTRL) begin
                r_d.rdata = {23'h0, r_q.fw_ok, 1'b0, r_q.pin_sel, 2'h0, r_q.period_time_base, r_q.run_request};
            end else if (REG_ADDR_I == MPW_REG_PERIOD) begin
                r_d.rdata = {16'h0, r_q.period_val};
            end else if (REG_ADDR_I == MPW_REG_DUTY) begin
                r_d.rdata = {25'h0, r_q.duty_percent};
            end else if (REG_ADDR_I == MPW_REG_STATUS) begin
                r_d.rdata = {24'h0, r_q.fault_code, r_q.fault_code != MPW_ERR_NONE, 2'h0, r_q.state};
            end else if (REG_ADDR_I == MPW_REG_IRQ_STAT) begin
                r_d.rdata = {29'h0, r_q.irq_stat};
            end else if (REG_ADDR_I == MPW_REG_IRQ_MASK) begin
                r_d.rdata = {29'h0, r_q.irq_mask};
            end else if (REG_ADDR_I == MPW_REG_CLAIMED) begin
                r_d.rdata = 32'(PIN_CLAIMED_I);
            end
        end

        // Run state machine
        case (r_q.state)
            MPW_ST_IDLE: begin
                r_d.pwm_out = '0;
                if (run_rise) begin
                    if (chk != MPW_ERR_NONE) begin
                        r_d.state = MPW_ST_FAULT;
                        r_d.fault_code = chk;
                        ev[MPW_IRQ_FAULT_BIT] = 1'b1;
                    end else begin
                        r_d.state = MPW_ST_RUN;
                        r_d.act_pin = r_q.pin_sel;
                        r_d.act_period = r_q.period_val;
                        r_d.act_duty = r_q.duty_percent;
                        r_d.unit_cnt = 16'h0000;
                        r_d.hund_cnt = 7'h00;
                        ev[MPW_IRQ_START_BIT] = 1'b1;
                    end
                end
            end
            MPW_ST_RUN: begin
                if (!r_q.run_request) begin
                    r_d.state = MPW_ST_IDLE;
                    r_d.pwm_out = '0;
                    ev[MPW_IRQ_STOP_BIT] = 1'b1;
                end else if (RUN_FAULT_I || chk != MPW_ERR_NONE) begin
                    r_d.state = MPW_ST_FAULT;
                    r_d.fault_code = RUN_FAULT_I ? MPW_ERR_RUNTIME : chk;
                    r_d.pwm_out = '0;
                    ev[MPW_IRQ_FAULT_BIT] = 1'b1;
                end else begin
                    // Period split into 100 slots of period units each
                    r_d.act_pin = r_q.pin_sel;
                    if (tick) begin
                        if (r_q.unit_cnt >= r_q.act_period - 16'h0001) begin
                            r_d.unit_cnt = 16'h0000;
                            if (r_q.hund_cnt == MPW_DUTY_MAX - 7'h01) begin
                                r_d.hund_cnt = 7'h00;
                                r_d.act_duty = r_q.duty_percent;
                                r_d.act_period = r_q.period_val;
                            end else begin
                                r_d.hund_cnt = r_q.hund_cnt + 7'h01;
                            end
                        end else begin
                            r_d.unit_cnt = r_q.unit_cnt + 16'h0001;
                        end
                    end
                    r_d.pwm_out = '0;
                    // Only the output contact bank is driven
                    r_d.pwm_out[r_q.act_pin] = r_q.hund_cnt < r_q.act_duty;
                end
            end
            MPW_ST_FAULT: begin
                r_d.pwm_out = '0;
                if (!r_q.run_request) begin
                    r_d.state = MPW_ST_IDLE;
                    r_d.fault_code = MPW_ERR_NONE;
                end
            end
            default: begin
                r_d.state = MPW_ST_IDLE;
            end
        endcase

        // Sticky events, set wins over write-one clear
        if (REG_WR_I && REG_ADDR_I == MPW_REG_IRQ_STAT) begin
            r_d.irq_stat = r_q.irq_stat & ~REG_WDATA_I[2:0];
        end
        r_d.irq_stat = r_d.irq_stat | ev;
        r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
    end

    // Single state register
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            r_q <= '0;
            r_q.period_time_base <= MPW_BASE_US;
            r_q.pin_sel <= MPW_PIN_RST;
            r_q.period_val <= MPW_PERIOD_RST;
            r_q.duty_percent <= MPW_DUTY_RST;
            r_q.fw_ok <= 1'b1;
            r_q.state <= MPW_ST_IDLE;
            r_q.fault_code <= MPW_ERR_NONE;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from the state register
    assign REG_RDATA_O = r_q.rdata;
    assign PWM_OUT_O = r_q.pwm_out;
    assign OUT_VALID_O = r_q.state == MPW_ST_RUN;
    assign IN_PROGRESS_O = r_q.state == MPW_ST_RUN;
    assign FAULT_FLAG_O = r_q.state == MPW_ST_FAULT;
    assign FAULT_CODE_O = r_q.fault_code;
    assign IRQ_O = r_q.irq;
endmodule : mpw_top
